// file: core/sdm_pkg.sv
// Purpose: Link constants and decode functions
// Assumes: One clock
// Notes:   Commands are {cs_n, ras_n, cas_n, we_n}
package sdm_pkg;
    // ==========================================================
    // Widths
    localparam int DQ_W    = 64;
    localparam int MASK_W  = 8;
    localparam int ADDR_W  = 12;
    localparam int BANK_W  = 2;
    localparam int COL_W   = 9;
    localparam int BEAT_W  = 10;
    localparam int NBANK   = 4;
    localparam int MEM_N   = 32;

    // ==========================================================
    // Mode register fields
    localparam int BL_LSB  = 0;
    localparam int BT_BIT  = 3;
    localparam int CL_LSB  = 4;
    localparam int OM_LSB  = 7;
    localparam int WBM_BIT = 9;
    localparam int AP_BIT  = 10;
    localparam logic [ADDR_W-1:0] MODE_RST = 12'h020;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_2    = 3'h2;
    localparam logic [2:0] CL_3    = 3'h3;
    localparam logic [BEAT_W-1:0] PAGE_BEATS = 10'h200;

    // ==========================================================
    // Commands
    localparam logic [3:0] CMD_INH = 4'h8;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD  = 4'h5;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_LMR = 4'h0;

    // ==========================================================
    // APB offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_ADDR  = 8'h04;
    localparam logic [7:0] OFS_WDLO  = 8'h08;
    localparam logic [7:0] OFS_WDHI  = 8'h0c;
    localparam logic [7:0] OFS_RDLO  = 8'h10;
    localparam logic [7:0] OFS_RDHI  = 8'h14;
    localparam logic [7:0] OFS_STAT  = 8'h18;
    localparam logic [7:0] OFS_MASK  = 8'h1c;

    // Reserved length codes act as one
    function automatic logic [BEAT_W-1:0] burst_beats(input logic [2:0] code);
        case (code)
            BL_2:    burst_beats = 10'h002;
            BL_4:    burst_beats = 10'h004;
            BL_8:    burst_beats = 10'h008;
            BL_PAGE: burst_beats = PAGE_BEATS;
            default: burst_beats = 10'h001;
        endcase
    endfunction

    // Reserved latency codes act as two
    function automatic logic [1:0] read_latency(input logic [2:0] code);
        read_latency = (code == CL_3) ? 2'h3 : 2'h2;
    endfunction
endpackage

// file: core/sdm_if.sv
// Purpose: Wires between controller and memory
// Assumes: One clock
// Notes:   Data resolved per byte, memory first
`timescale 1ns/1ns
interface sdm_if;
    logic                        cs_n;
    logic                        ras_n;
    logic                        cas_n;
    logic                        we_n;
    logic                        cke;
    logic [sdm_pkg::BANK_W-1:0]  ba;
    logic [sdm_pkg::ADDR_W-1:0]  addr;
    logic [sdm_pkg::MASK_W-1:0]  dqm;
    logic [sdm_pkg::DQ_W-1:0]    host_dq_o;
    logic [sdm_pkg::MASK_W-1:0]  host_dq_oe_n;
    logic [sdm_pkg::DQ_W-1:0]    dev_dq_o;
    logic [sdm_pkg::MASK_W-1:0]  dev_dq_oe_n;
    logic [sdm_pkg::DQ_W-1:0]    dq;

    // ==========================================================
    // Undriven bytes read zero
    for (genvar b = 0; b < sdm_pkg::MASK_W; b++) begin : g_res
        assign dq[b*8 +: 8] = !dev_dq_oe_n[b]  ? dev_dq_o[b*8 +: 8] :
                              !host_dq_oe_n[b] ? host_dq_o[b*8 +: 8] : 8'h00;
    end

    modport dev  (input cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, dq,
                  output dev_dq_o, dev_dq_oe_n);
    modport host (output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm,
                  host_dq_o, host_dq_oe_n, input dq);
endinterface

// file: core/sdm_dev.sv
// Purpose: Memory end: mode, decode, burst, latency
// Assumes: Controller logic on the same clock
// Notes:   Only 32 words, so columns alias
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns

// What this block does
// - Type bit picks sequential or interleaved
// - Read latency two or three
// - Drive after n+m-1, valid at n+m
// - Length two: bit 0 is start
// - Length four: bits 1..0 start, wrap
// - Length eight: bits 2..0 start, wrap
// - Full page, 512 columns, sequential only
// - Length one: one column, type ignored
// - Operating mode bits stored as loaded, not checked
// - Write burst bit makes single writes
// - Reserved latency codes act as two
// - Strobe decode: inhibit, NOP, terminate
// - Active opens bank row
// - Read and write pick bank, column
// - Bit ten asks auto precharge
// - Precharge one or all banks
// - Refresh, or self refresh if disabled
// - Refresh row from internal counter
// - Mode load takes address bits
// - Mask: writes now, reads two late
// - Mode register field layout
// - Mode load taken even with banks open
module sdm_dev (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // Link
    sdm_if.dev                              lnk,
    // Status
    output wire logic [sdm_pkg::ADDR_W-1:0] mode_q,
    output wire logic [sdm_pkg::NBANK-1:0]  bank_open,
    output wire logic                       self_refresh,
    output wire logic [sdm_pkg::ADDR_W-1:0] refresh_row
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RD   = 4'h2,
        ST_WR   = 4'h4,
        ST_SREF = 4'h8
    } sdm_dst_t;

    typedef struct packed {
        sdm_dst_t                                          state;
        logic [sdm_pkg::ADDR_W-1:0]                        mode;
        logic [sdm_pkg::NBANK-1:0]                         row_open;
        logic [sdm_pkg::NBANK-1:0][sdm_pkg::ADDR_W-1:0]    open_row;
        logic [sdm_pkg::ADDR_W-1:0]                        ref_row;
        logic [sdm_pkg::BANK_W-1:0]                        bank;
        logic [sdm_pkg::COL_W-1:0]                         start;
        logic [sdm_pkg::BEAT_W-1:0]                        beat;
        logic [sdm_pkg::BEAT_W-1:0]                        beats;
        logic                                              inter;
        logic                                              ap;
        logic                                              p1_v;
        logic [sdm_pkg::DQ_W-1:0]                          p1_d;
        logic                                              p2_v;
        logic [sdm_pkg::DQ_W-1:0]                          p2_d;
        logic [sdm_pkg::MASK_W-1:0]                        dqm_d;
        logic [sdm_pkg::DQ_W-1:0]                          dq_o;
        logic [sdm_pkg::MASK_W-1:0]                        oe_n;
        logic [sdm_pkg::MEM_N-1:0][sdm_pkg::DQ_W-1:0]      mem;
    } sdm_dev_t;

    sdm_dev_t r_reg;
    sdm_dev_t r_next;

    // ==========================================================
    // Burst column for a given beat
    function automatic logic [sdm_pkg::COL_W-1:0] beat_col(
        input logic [sdm_pkg::COL_W-1:0]  st,
        input logic [sdm_pkg::BEAT_W-1:0] k,
        input logic [sdm_pkg::BEAT_W-1:0] n,
        input logic                       il
    );
        logic [sdm_pkg::COL_W-1:0] msk;
        logic [sdm_pkg::COL_W-1:0] kk;
        msk = n[sdm_pkg::COL_W-1:0] - 9'h001;
        kk  = k[sdm_pkg::COL_W-1:0];
        if (n == sdm_pkg::PAGE_BEATS) begin
            beat_col = st + kk;
        end else if (il) begin
            beat_col = (st & ~msk) | ((st ^ kk) & msk);
        end else begin
            beat_col = (st & ~msk) | ((st + kk) & msk);
        end
    endfunction

    function automatic logic [4:0] mem_idx(
        input logic [sdm_pkg::BANK_W-1:0] b,
        input logic [sdm_pkg::COL_W-1:0]  c
    );
        mem_idx = {b, c[2:0]};
    endfunction

    // ==========================================================
    // Next state
    logic [3:0]                 cmd;
    logic                       beat_v;
    logic                       beat_wr;
    logic [sdm_pkg::BANK_W-1:0] bbank;
    logic [sdm_pkg::COL_W-1:0]  bst;
    logic [sdm_pkg::COL_W-1:0]  bcol;
    logic [sdm_pkg::BEAT_W-1:0] bnum;
    logic [sdm_pkg::BEAT_W-1:0] btot;
    logic                       bil;
    logic                       bap;
    logic [4:0]                 idx;
    logic                       src_v;
    logic [sdm_pkg::DQ_W-1:0]   src_d;

    always_comb begin
        r_next  = r_reg;
        cmd     = lnk.cs_n ? sdm_pkg::CMD_INH
                           : {1'b0, lnk.ras_n, lnk.cas_n, lnk.we_n};
        beat_v  = 1'b0;
        beat_wr = 1'b0;
        bbank   = r_reg.bank;
        bst     = r_reg.start;
        bnum    = r_reg.beat;
        btot    = r_reg.beats;
        bil     = r_reg.inter;
        bap     = r_reg.ap;
        r_next.p1_v  = 1'b0;
        r_next.dqm_d = lnk.dqm;

        if (r_reg.state == ST_SREF) begin
            // Only clock enable counts here
            if (lnk.cke) begin
                r_next.state = ST_IDLE;
            end
        end else if (!lnk.cke) begin
            if (cmd == sdm_pkg::CMD_REF) begin
                r_next.state = ST_SREF;
            end
        end else begin
            case (cmd)
                sdm_pkg::CMD_RD, sdm_pkg::CMD_WR: begin
                    beat_v  = 1'b1;
                    beat_wr = (cmd == sdm_pkg::CMD_WR);
                    bbank   = lnk.ba;
                    bst     = lnk.addr[sdm_pkg::COL_W-1:0];
                    bnum    = '0;
                    bil     = r_reg.mode[sdm_pkg::BT_BIT];
                    bap     = lnk.addr[sdm_pkg::AP_BIT];
                    btot    = sdm_pkg::burst_beats(r_reg.mode[sdm_pkg::BL_LSB +: 3]);
                    if (beat_wr && r_reg.mode[sdm_pkg::WBM_BIT]) begin
                        btot = 10'h001;
                    end
                end
                sdm_pkg::CMD_BST: begin
                    r_next.state = ST_IDLE;
                end
                sdm_pkg::CMD_ACT: begin
                    r_next.row_open[lnk.ba] = 1'b1;
                    r_next.open_row[lnk.ba] = lnk.addr;
                end
                sdm_pkg::CMD_PRE: begin
                    if (lnk.addr[sdm_pkg::AP_BIT]) begin
                        r_next.row_open = '0;
                    end else begin
                        r_next.row_open[lnk.ba] = 1'b0;
                    end
                end
                sdm_pkg::CMD_REF: begin
                    r_next.ref_row = r_reg.ref_row + 12'h001;
                end
                sdm_pkg::CMD_LMR: begin
                    r_next.mode = lnk.addr;
                end
                default: begin
                    // Idle strobes continue a burst
                    beat_v  = (r_reg.state == ST_RD) || (r_reg.state == ST_WR);
                    beat_wr = (r_reg.state == ST_WR);
                end
            endcase
        end

        // Length one: zero mask, type ignored
        bcol = beat_col(bst, bnum, btot, bil);
        idx  = mem_idx(bbank, bcol);
        if (beat_v) begin
            if (beat_wr) begin
                for (int b = 0; b < sdm_pkg::MASK_W; b++) begin
                    if (!lnk.dqm[b]) begin
                        r_next.mem[idx][b*8 +: 8] = lnk.dq[b*8 +: 8];
                    end
                end
            end else begin
                r_next.p1_v = 1'b1;
                r_next.p1_d = r_reg.mem[idx];
            end
            r_next.bank  = bbank;
            r_next.start = bst;
            r_next.beats = btot;
            r_next.inter = bil;
            r_next.ap    = bap;
            r_next.beat  = bnum + 10'h001;
            if (bnum + 10'h001 == btot) begin
                r_next.state = ST_IDLE;
                if (bap) begin
                    r_next.row_open[bbank] = 1'b0;
                end
            end else begin
                r_next.state = beat_wr ? ST_WR : ST_RD;
            end
        end

        // Output loads at edge n+m-1
        r_next.p2_v = r_reg.p1_v;
        r_next.p2_d = r_reg.p1_d;
        if (sdm_pkg::read_latency(r_reg.mode[sdm_pkg::CL_LSB +: 3]) == 2'h3) begin
            src_v = r_reg.p2_v;
            src_d = r_reg.p2_d;
        end else begin
            src_v = r_reg.p1_v;
            src_d = r_reg.p1_d;
        end
        if (src_v) begin
            r_next.dq_o = src_d;
            r_next.oe_n = r_reg.dqm_d;
        end else begin
            r_next.oe_n = '1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r_reg       <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.mode  <= sdm_pkg::MODE_RST;
            r_reg.oe_n  <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs
    assign lnk.dev_dq_o    = r_reg.dq_o;
    assign lnk.dev_dq_oe_n = r_reg.oe_n;
    assign mode_q          = r_reg.mode;
    assign bank_open       = r_reg.row_open;
    assign self_refresh    = (r_reg.state == ST_SREF);
    assign refresh_row     = r_reg.ref_row;
endmodule

// file: core/sdm_host.sv
// Purpose: Controller end, APB to commands
// Assumes: Software sequences banks and mode
// Notes:   Keeps first read word only
`timescale 1ns/1ns
module sdm_host (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output wire logic         pready,
    output wire logic         pslverr,
    // Link
    sdm_if.host               lnk
);
    typedef struct packed {
        logic [3:0]                  cmd;
        logic                        cke;
        logic [sdm_pkg::BANK_W-1:0]  ba;
        logic [sdm_pkg::ADDR_W-1:0]  addr;
        logic [sdm_pkg::MASK_W-1:0]  dqm;
        logic [sdm_pkg::DQ_W-1:0]    wdata;
        logic [sdm_pkg::DQ_W-1:0]    rdata;
        logic                        rd_done;
        logic [sdm_pkg::ADDR_W-1:0]  mode;
        logic [1:0]                  rcnt;
        logic                        rbusy;
        logic [sdm_pkg::BEAT_W-1:0]  wcnt;
        logic [sdm_pkg::MASK_W-1:0]  oe_n;
    } sdm_host_t;

    sdm_host_t r_reg;
    sdm_host_t r_next;
    logic      wr_acc;
    logic      busy;

    // ==========================================================
    // Register access and command issue
    assign wr_acc = psel && penable && pwrite;
    assign busy   = r_reg.rbusy || !r_reg.oe_n[0];

    always_comb begin
        r_next      = r_reg;
        r_next.cmd  = sdm_pkg::CMD_INH;
        if (r_reg.rbusy) begin
            if (r_reg.rcnt == 2'h0) begin
                r_next.rdata   = lnk.dq;
                r_next.rd_done = 1'b1;
                r_next.rbusy   = 1'b0;
            end else begin
                r_next.rcnt = r_reg.rcnt - 2'h1;
            end
        end
        if (r_reg.wcnt > 10'h001) begin
            r_next.wcnt = r_reg.wcnt - 10'h001;
        end else begin
            r_next.wcnt = '0;
            r_next.oe_n = '1;
        end
        if (wr_acc) begin
            case (paddr)
                sdm_pkg::OFS_ADDR: begin
                    r_next.addr = pwdata[sdm_pkg::ADDR_W-1:0];
                    r_next.ba   = pwdata[13:12];
                end
                sdm_pkg::OFS_WDLO: r_next.wdata[31:0]  = pwdata;
                sdm_pkg::OFS_WDHI: r_next.wdata[63:32] = pwdata;
                sdm_pkg::OFS_MASK: begin
                    r_next.dqm = pwdata[sdm_pkg::MASK_W-1:0];
                    r_next.cke = pwdata[8];
                end
                sdm_pkg::OFS_CTRL: begin
                    // Commands arriving while busy are dropped
                    if (!busy) begin
                        r_next.cmd = pwdata[3:0];
                        if (pwdata[3:0] == sdm_pkg::CMD_LMR) begin
                            r_next.mode = r_reg.addr;
                        end
                        if (pwdata[3:0] == sdm_pkg::CMD_RD) begin
                            r_next.rbusy   = 1'b1;
                            r_next.rd_done = 1'b0;
                            r_next.rcnt    = sdm_pkg::read_latency(
                                r_reg.mode[sdm_pkg::CL_LSB +: 3]);
                        end
                        if (pwdata[3:0] == sdm_pkg::CMD_WR) begin
                            r_next.oe_n = '0;
                            r_next.wcnt = r_reg.mode[sdm_pkg::WBM_BIT] ? 10'h001 :
                                sdm_pkg::burst_beats(r_reg.mode[sdm_pkg::BL_LSB +: 3]);
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r_reg      <= '0;
            r_reg.cmd  <= sdm_pkg::CMD_INH;
            r_reg.cke  <= 1'b1;
            r_reg.mode <= sdm_pkg::MODE_RST;
            r_reg.oe_n <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Read data and outputs
    always_comb begin
        case (paddr)
            sdm_pkg::OFS_CTRL: prdata = {28'h0, r_reg.cmd};
            sdm_pkg::OFS_ADDR: prdata = {18'h0, r_reg.ba, r_reg.addr};
            sdm_pkg::OFS_WDLO: prdata = r_reg.wdata[31:0];
            sdm_pkg::OFS_WDHI: prdata = r_reg.wdata[63:32];
            sdm_pkg::OFS_RDLO: prdata = r_reg.rdata[31:0];
            sdm_pkg::OFS_RDHI: prdata = r_reg.rdata[63:32];
            sdm_pkg::OFS_STAT: prdata = {30'h0, r_reg.rd_done, busy};
            sdm_pkg::OFS_MASK: prdata = {23'h0, r_reg.cke, r_reg.dqm};
            default:           prdata = 32'h0;
        endcase
    end

    assign pready           = 1'b1;
    assign pslverr          = 1'b0;
    assign {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} = r_reg.cmd;
    assign lnk.cke          = r_reg.cke;
    assign lnk.ba           = r_reg.ba;
    assign lnk.addr         = r_reg.addr;
    assign lnk.dqm          = r_reg.dqm;
    assign lnk.host_dq_o    = r_reg.wdata;
    assign lnk.host_dq_oe_n = r_reg.oe_n;
endmodule

// file: test/sdm_props.sv
// Purpose: Link properties
// Assumes: One clock
// Notes:   Mode shadowed from the link
`timescale 1ns/1ns
module sdm_props (
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       reset_n,
    // Command
    input wire logic                       cs_n,
    input wire logic                       ras_n,
    input wire logic                       cas_n,
    input wire logic                       we_n,
    input wire logic                       cke,
    input wire logic [sdm_pkg::ADDR_W-1:0] addr,
    // Data enables and mask
    input wire logic [sdm_pkg::MASK_W-1:0] dqm,
    input wire logic [sdm_pkg::MASK_W-1:0] host_dq_oe_n,
    input wire logic [sdm_pkg::MASK_W-1:0] dev_dq_oe_n
);
    typedef struct packed {
        logic [sdm_pkg::ADDR_W-1:0] mode;
        logic                       sr;
    } sdm_chk_t;
    sdm_chk_t   st_reg;
    sdm_chk_t   st_next;
    logic [3:0] cmd;
    logic       rd;
    logic       wr;
    logic       cl2;
    logic       q0;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign rd  = cke && cmd == sdm_pkg::CMD_RD;
    assign wr  = cke && cmd == sdm_pkg::CMD_WR;
    assign cl2 = st_reg.mode[6:4] != sdm_pkg::CL_3;
    assign q0  = cs_n && dqm == 8'h00;
    // ==========================================================
    // Shadow of the memory's mode
    always_comb begin
        st_next = st_reg;
        if (cke && cmd == sdm_pkg::CMD_LMR) begin
            st_next.mode = addr;
        end
        st_next.sr = cke ? 1'b0 : (st_reg.sr || cmd == sdm_pkg::CMD_REF);
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg <= '{mode: sdm_pkg::MODE_RST, sr: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_cmd_pulse;
        !cs_n |=> cs_n;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse)
        else $error("long strobe");
    property p_wr_drive;
        wr |-> host_dq_oe_n != 8'hff;
    endproperty
    a_wr_drive: assert property (p_wr_drive)
        else $error("no write data");
    property p_wr_single;
        wr && (st_reg.mode[9] || st_reg.mode[2:0] == sdm_pkg::BL_1) |=> host_dq_oe_n == 8'hff;
    endproperty
    a_wr_single: assert property (p_wr_single)
        else $error("extra write beat");
    property p_rd_bl1;
        rd && cl2 && st_reg.mode[2:0] == sdm_pkg::BL_1 && dqm == 8'h00 ##1 q0
            |-> ##1 dev_dq_oe_n == 8'h00 ##1 dev_dq_oe_n == 8'hff;
    endproperty
    a_rd_bl1: assert property (p_rd_bl1)
        else $error("bl1 read");
    property p_rd_bl2;
        rd && cl2 && st_reg.mode[2:0] == sdm_pkg::BL_2 && dqm == 8'h00 ##1 q0 ##1 cs_n
            |-> (dev_dq_oe_n == 8'h00)[*2] ##1 dev_dq_oe_n == 8'hff;
    endproperty
    a_rd_bl2: assert property (p_rd_bl2)
        else $error("bl2 read");
    property p_rd_cl3;
        rd && !cl2 && dqm == 8'h00 ##1 q0 ##1 cs_n |-> ##1 dev_dq_oe_n == 8'h00;
    endproperty
    a_rd_cl3: assert property (p_rd_cl3)
        else $error("cl3 read");
    property p_rd_mask;
        dev_dq_oe_n != 8'hff |-> ($past(dqm, 2) & ~dev_dq_oe_n) == 8'h00;
    endproperty
    a_rd_mask: assert property (p_rd_mask)
        else $error("masked byte");
    property p_sr_quiet;
        st_reg.sr && !cke && dev_dq_oe_n == 8'hff && $past(dqm) == 8'h00
            && $past(dqm, 2) == 8'h00 |=> dev_dq_oe_n == 8'hff;
    endproperty
    a_sr_quiet: assert property (p_sr_quiet)
        else $error("sref drive");
endmodule

// file: test/tb.sv
// Purpose: Self-checking bench
// Assumes: Fixed seed
// Notes:   Order seen on column bits 2..0
`timescale 1ns/1ns
module tb;
    logic        clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rv;
    logic [31:0] base;
    logic [11:0] mode_q;
    logic [11:0] refresh_row;
    logic [3:0]  bank_open;
    logic        self_refresh;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    sdm_if lnk ();
    sdm_host i_sdm_host (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lnk(lnk));
    sdm_dev i_sdm_dev (.clk(clk), .reset_n(reset_n), .lnk(lnk), .mode_q(mode_q),
        .bank_open(bank_open), .self_refresh(self_refresh), .refresh_row(refresh_row));
    sdm_props i_sdm_props (.clk(clk), .reset_n(reset_n), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n),
        .cas_n(lnk.cas_n), .we_n(lnk.we_n), .cke(lnk.cke), .addr(lnk.addr), .dqm(lnk.dqm),
        .host_dq_oe_n(lnk.host_dq_oe_n), .dev_dq_oe_n(lnk.dev_dq_oe_n));
    // ==========================================================
    // Helpers
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Busy drops a command, so wait idle
    task automatic cmd(input logic [3:0] c, input logic [13:0] a);
        apb(1'b0, sdm_pkg::OFS_STAT, 32'h0);
        while (rv[0] !== 1'b0) apb(1'b0, sdm_pkg::OFS_STAT, 32'h0);
        apb(1'b1, sdm_pkg::OFS_ADDR, {18'h0, a});
        apb(1'b1, sdm_pkg::OFS_CTRL, {28'h0, c});
    endtask
    function automatic logic [63:0] dat(input logic [2:0] c);
        return {base ^ {29'h0, c}, ~base + {29'h0, c}};
    endfunction
    function automatic logic [63:0] mexp(input logic [7:0] m);
        for (int j = 0; j < 8; j++) mexp[j*8 +: 8] = {8{~m[j]}};
    endfunction
    // ==========================================================
    // Clock, timeout, sequence
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            test_done;
        end
    end
    initial begin
        int i, k, n;
        logic [8:0] s, w, cc;
        logic [2:0] cl, bl;
        logic [7:0] dm;
        logic [1:0] b;
        logic       t, ap;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        base = $urandom(78843);
        b = 2'($urandom);
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        #1 chk(64'(mode_q), 64'(sdm_pkg::MODE_RST));
        apb(1'b0, 8'h40, 32'h0);
        chk(64'(rv), 64'h0);
        chk(64'(pslverr), 64'h0);
        $display("reset test done");
        cmd(sdm_pkg::CMD_LMR, 14'h0223);
        @(posedge clk);
        #1 chk(64'(mode_q), 64'h223);
        cmd(sdm_pkg::CMD_ACT, {b, 12'h0});
        apb(1'b1, sdm_pkg::OFS_MASK, 32'h100);
        for (k = 0; k < 8; k++) begin
            apb(1'b1, sdm_pkg::OFS_WDLO, 32'(dat(3'(k))));
            apb(1'b1, sdm_pkg::OFS_WDHI, 32'(dat(3'(k)) >> 32));
            cmd(sdm_pkg::CMD_WR, {b, 3'h0, 6'($urandom), 3'(k)});
        end
        for (i = 0; i < 17; i++) begin
            bl = (i == 16) ? sdm_pkg::BL_PAGE : 3'(i % 4);
            n = (i == 16) ? 12 : (1 << (i % 4));
            w = (i == 16) ? 9'h1ff : 9'(n - 1);
            t = (i == 16) ? 1'b0 : i[2];
            cl = i[3] ? 3'h3 : 3'h2;
            dm = t ? 8'($urandom) : 8'h00;
            ap = (i != 16) && 1'($urandom);
            s = (i == 16) ? 9'h1fc : 9'($urandom);
            cmd(sdm_pkg::CMD_LMR, {7'h0, cl, t, bl});
            cmd(sdm_pkg::CMD_ACT, {b, 12'h0});
            apb(1'b1, sdm_pkg::OFS_MASK, {23'h0, 1'b1, dm});
            cmd(sdm_pkg::CMD_RD, {b, 1'b0, ap, 1'b0, s});
            repeat (int'(cl)) @(posedge clk);
            for (k = 0; k < n; k++) begin
                cc = t ? (s ^ 9'(k)) : ((s & ~w) | ((s + 9'(k)) & w));
                #1 chk(lnk.dq, dat(cc[2:0]) & mexp(dm));
                @(posedge clk);
            end
            if (i == 16) begin
                cmd(sdm_pkg::CMD_BST, 14'h0);
                repeat (2) @(posedge clk);
            end
            #1 chk(64'(lnk.dev_dq_oe_n), 64'hff);
            chk(64'(bank_open[b]), 64'(!ap));
            apb(1'b0, sdm_pkg::OFS_RDLO, 32'h0);
            chk(64'(rv), 64'(dat(s[2:0]) & mexp(dm)) & 64'hffffffff);
            $display("burst test %0d done", i);
        end
        for (k = 0; k < 4; k++) cmd(sdm_pkg::CMD_ACT, {2'(k), 12'h0});
        cmd(sdm_pkg::CMD_PRE, {2'h2, 12'h0});
        @(posedge clk);
        #1 chk(64'(bank_open), 64'hb);
        cmd(sdm_pkg::CMD_PRE, {2'h1, 12'h400});
        @(posedge clk);
        #1 chk(64'(bank_open), 64'h0);
        $display("precharge test done");
        cc = 9'(refresh_row);
        cmd(sdm_pkg::CMD_REF, 14'h0);
        @(posedge clk);
        #1 chk(64'(refresh_row), 64'(12'(cc) + 12'h001));
        apb(1'b1, sdm_pkg::OFS_MASK, 32'h0);
        cmd(sdm_pkg::CMD_REF, 14'h0);
        @(posedge clk);
        #1 chk(64'(self_refresh), 64'h1);
        apb(1'b1, sdm_pkg::OFS_MASK, 32'h100);
        @(posedge clk);
        #1 chk(64'(self_refresh), 64'h0);
        $display("refresh test done");
        test_done;
    end
endmodule
